// ---- src/ecb_cam_block.sv ----
// Purpose: 32 x 32 content-addressable memory with ternary bits,
//   encoded or two-beat unencoded match output, AHB-Lite registers
// Assumes: single clock hclk; input and output sides pace by dividers
// Notes on behaviour
// - thirty-two entries of thirty-two bits, key compared against all
// - a don't-care stored bit never blocks its entry from matching
// - encoded mode presents the binary index of the matching entry
// - unencoded mode drives one of sixteen lines per matching entry
// - unencoded result comes in two beats: entries 0-15 then 16-31
// - duplicates make the encoded index unreliable; flag them
// - a write takes two cycles, three when don't-care bits present
// - entries hold initial contents from reset and accept live writes
// - input side and output side registers run at independent rates
// - six signal stages each selectable registered or bypassed
// - registers obey a clock enable and a clear from user logic
module ecb_cam_block (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // match result
  output logic [ecb_pkg::LINES-1:0] match_lines,
  output logic [ecb_pkg::IDX_W-1:0] match_index,
  output logic match_found,
  output logic match_multi,
  output logic result_half,
  output logic result_valid
);

  // ==========================================================
  // helpers
  function automatic logic [ecb_pkg::IDX_W-1:0] first_hit(
    input logic [ecb_pkg::ENTRIES-1:0] v);
    logic [ecb_pkg::IDX_W-1:0] r;
    r = '0;
    for (int i = ecb_pkg::ENTRIES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = ecb_pkg::IDX_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [ecb_pkg::OFF_W-1:0] a,
    input logic [ecb_pkg::OFF_W-1:0] off);
    return a == off;
  endfunction

  // ==========================================================
  // declarations
  logic [ecb_pkg::CTRL_W-1:0] ctrl;
  logic [31:0] wdata;
  logic [31:0] wmask;
  logic [31:0] key;
  logic [ecb_pkg::IDX_W-1:0] waddr;
  logic [ecb_pkg::IDX_W-1:0] raddr;
  logic [ecb_pkg::DIV_W-1:0] div_in;
  logic [ecb_pkg::DIV_W-1:0] div_out;
  logic [ecb_pkg::DIV_W-1:0] cnt_in;
  logic [ecb_pkg::DIV_W-1:0] cnt_out;
  logic [31:0] entry_data [ecb_pkg::ENTRIES];
  logic [31:0] entry_mask [ecb_pkg::ENTRIES];
  logic [31:0] din_wdata;
  logic [31:0] din_wmask;
  logic [31:0] din_key;
  logic [ecb_pkg::IDX_W-1:0] waddr_q;
  logic [ecb_pkg::IDX_W-1:0] raddr_q;
  logic wstb_pend;
  logic rstb_pend;
  ecb_pkg::ecb_wr_state_type wr_state;
  ecb_pkg::ecb_out_state_type out_state;
  logic [ecb_pkg::IDX_W-1:0] wr_addr_l;
  logic [31:0] wr_data_l;
  logic [31:0] wr_mask_l;
  logic [31:0] key_cmp;
  logic cmp_pending;
  logic [ecb_pkg::ENTRIES-1:0] match_q;
  logic [ecb_pkg::OFF_W-1:0] addr_q;
  logic write_q;
  logic pend;
  logic [31:0] rd_mux;

  // ==========================================================
  // pacing and stage selection
  wire clken = ctrl[ecb_pkg::CTRL_CLKEN];
  wire tick_in = clken && (cnt_in >= div_in);
  wire tick_out = clken && (cnt_out >= div_out);
  wire [31:0] wdata_sel = ctrl[ecb_pkg::CTRL_REG_DIN] ? din_wdata : wdata;
  wire [31:0] wmask_sel = ctrl[ecb_pkg::CTRL_REG_DIN] ? din_wmask : wmask;
  wire [31:0] key_sel = ctrl[ecb_pkg::CTRL_REG_DIN] ? din_key : key;
  wire [ecb_pkg::IDX_W-1:0] waddr_sel =
    ctrl[ecb_pkg::CTRL_REG_WADDR] ? waddr_q : waddr;
  wire [ecb_pkg::IDX_W-1:0] raddr_sel =
    ctrl[ecb_pkg::CTRL_REG_RADDR] ? raddr_q : raddr;
  wire wstb_go = ctrl[ecb_pkg::CTRL_REG_WSTB] ? tick_in : clken;
  wire rstb_go = ctrl[ecb_pkg::CTRL_REG_RSTB] ? tick_in : clken;
  wire out_step = ctrl[ecb_pkg::CTRL_REG_DOUT] ? tick_out : clken;
  wire encoded = ctrl[ecb_pkg::CTRL_ENC];

  // ==========================================================
  // bus decode
  wire accept = hsel && hready && htrans[ecb_pkg::HTRANS_ACTIVE];
  wire bus_we = pend && write_q;
  wire we_ctrl = bus_we && hit(addr_q, ecb_pkg::OFF_CTRL);
  wire we_cmd = bus_we && hit(addr_q, ecb_pkg::OFF_CMD);
  wire clr = we_ctrl && hwdata[ecb_pkg::CTRL_CLEAR];
  wire busy = wstb_pend || (wr_state != ecb_pkg::WR_IDLE);
  wire go_w = wstb_pend && (wr_state == ecb_pkg::WR_IDLE) && wstb_go;
  wire go_s = rstb_pend && rstb_go;
  wire commit = tick_in && ((wr_state == ecb_pkg::WR_THREE) ||
    ((wr_state == ecb_pkg::WR_TWO) && (wr_mask_l == '0)));
  wire load_low = (out_state == ecb_pkg::OUT_IDLE) && cmp_pending &&
    out_step;

  // ==========================================================
  // compare array
  wire [ecb_pkg::ENTRIES-1:0] match;
  genvar g;
  generate
    for (g = 0; g < ecb_pkg::ENTRIES; g++) begin : gen_cmp
      assign match[g] =
        ((entry_data[g] ^ key_cmp) & ~entry_mask[g]) == '0;
    end
  endgenerate
  wire hit_any = |match;
  wire multi = (match & (match - 1'b1)) != '0;
  wire [ecb_pkg::IDX_W-1:0] enc_idx = first_hit(match);

  // ==========================================================
  // read multiplexer
  always_comb begin
    rd_mux = '0;
    if (hit(addr_q, ecb_pkg::OFF_CTRL)) begin
      rd_mux[ecb_pkg::CTRL_W-1:0] = ctrl;
    end else if (hit(addr_q, ecb_pkg::OFF_WDATA)) begin
      rd_mux = wdata;
    end else if (hit(addr_q, ecb_pkg::OFF_WMASK)) begin
      rd_mux = wmask;
    end else if (hit(addr_q, ecb_pkg::OFF_WADDR)) begin
      rd_mux[ecb_pkg::IDX_W-1:0] = waddr;
    end else if (hit(addr_q, ecb_pkg::OFF_KEY)) begin
      rd_mux = key;
    end else if (hit(addr_q, ecb_pkg::OFF_STATUS)) begin
      rd_mux[ecb_pkg::ST_BUSY] = busy;
      rd_mux[ecb_pkg::ST_VALID] = result_valid;
      rd_mux[ecb_pkg::ST_FOUND] = match_found;
      rd_mux[ecb_pkg::ST_MULTI] = match_multi;
      rd_mux[ecb_pkg::ST_HALF] = result_half;
      rd_mux[ecb_pkg::ST_SEARCH] = rstb_pend || cmp_pending ||
        (out_state != ecb_pkg::OUT_IDLE);
      rd_mux[ecb_pkg::ST_IDX_LO +: ecb_pkg::IDX_W] = match_index;
    end else if (hit(addr_q, ecb_pkg::OFF_RESULT)) begin
      rd_mux[ecb_pkg::LINES-1:0] = match_lines;
      rd_mux[ecb_pkg::RES_HALF] = result_half;
    end else if (hit(addr_q, ecb_pkg::OFF_DIVIN)) begin
      rd_mux[ecb_pkg::DIV_W-1:0] = div_in;
    end else if (hit(addr_q, ecb_pkg::OFF_DIVOUT)) begin
      rd_mux[ecb_pkg::DIV_W-1:0] = div_out;
    end else if (hit(addr_q, ecb_pkg::OFF_RADDR)) begin
      rd_mux[ecb_pkg::IDX_W-1:0] = raddr;
    end else if (hit(addr_q, ecb_pkg::OFF_RDATA)) begin
      rd_mux = entry_data[raddr_sel];
    end
  end

  // ==========================================================
  // ahb-lite slave: one wait state on every transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      write_q <= 1'b0;
      addr_q <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= ecb_pkg::RESP_OKAY;
    end else begin
      hresp <= ecb_pkg::RESP_OKAY;
      pend <= accept;
      if (accept) begin
        addr_q <= haddr[ecb_pkg::OFF_W-1:0];
        write_q <= hwrite;
        hreadyout <= 1'b0;
      end else if (pend) begin
        hreadyout <= 1'b1;
        hrdata <= write_q ? '0 : rd_mux;
      end
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= ecb_pkg::CTRL_RESET;
      wdata <= '0;
      wmask <= '0;
      key <= '0;
      waddr <= '0;
      raddr <= '0;
      div_in <= ecb_pkg::DIV_RESET;
      div_out <= ecb_pkg::DIV_RESET;
    end else if (bus_we) begin
      if (hit(addr_q, ecb_pkg::OFF_CTRL)) begin
        ctrl <= hwdata[ecb_pkg::CTRL_W-1:0];
      end else if (hit(addr_q, ecb_pkg::OFF_WDATA)) begin
        wdata <= hwdata;
      end else if (hit(addr_q, ecb_pkg::OFF_WMASK)) begin
        wmask <= hwdata;
      end else if (hit(addr_q, ecb_pkg::OFF_WADDR)) begin
        waddr <= hwdata[ecb_pkg::IDX_W-1:0];
      end else if (hit(addr_q, ecb_pkg::OFF_KEY)) begin
        key <= hwdata;
      end else if (hit(addr_q, ecb_pkg::OFF_DIVIN)) begin
        div_in <= hwdata[ecb_pkg::DIV_W-1:0];
      end else if (hit(addr_q, ecb_pkg::OFF_DIVOUT)) begin
        div_out <= hwdata[ecb_pkg::DIV_W-1:0];
      end else if (hit(addr_q, ecb_pkg::OFF_RADDR)) begin
        raddr <= hwdata[ecb_pkg::IDX_W-1:0];
      end
    end
  end

  // ==========================================================
  // side pacing counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_in <= '0;
      cnt_out <= '0;
    end else begin
      cnt_in <= (cnt_in >= div_in) ? '0 : cnt_in + 1'b1;
      cnt_out <= (cnt_out >= div_out) ? '0 : cnt_out + 1'b1;
    end
  end

  // input stage registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_wdata <= '0;
      din_wmask <= '0;
      din_key <= '0;
      waddr_q <= '0;
      raddr_q <= '0;
    end else if (clr) begin
      din_wdata <= '0;
      din_wmask <= '0;
      din_key <= '0;
      waddr_q <= '0;
      raddr_q <= '0;
    end else if (tick_in) begin
      din_wdata <= wdata;
      din_wmask <= wmask;
      din_key <= key;
      waddr_q <= waddr;
      raddr_q <= raddr;
    end
  end

  // strobes; a new command beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wstb_pend <= 1'b0;
      rstb_pend <= 1'b0;
    end else begin
      if (go_w || clr) begin
        wstb_pend <= 1'b0;
      end
      if (we_cmd && hwdata[ecb_pkg::CMD_WRITE] && !busy) begin
        wstb_pend <= 1'b1;
      end
      if (go_s || clr) begin
        rstb_pend <= 1'b0;
      end
      if (we_cmd && hwdata[ecb_pkg::CMD_SEARCH]) begin
        rstb_pend <= 1'b1;
      end
    end
  end

  // ==========================================================
  // write sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_state <= ecb_pkg::WR_IDLE;
      wr_addr_l <= '0;
      wr_data_l <= '0;
      wr_mask_l <= '0;
    end else if (clr) begin
      wr_state <= ecb_pkg::WR_IDLE;
    end else begin
      case (wr_state)
        ecb_pkg::WR_IDLE: begin
          if (go_w) begin
            wr_addr_l <= waddr_sel;
            wr_data_l <= wdata_sel;
            wr_mask_l <= wmask_sel;
            wr_state <= ecb_pkg::WR_ONE;
          end
        end
        ecb_pkg::WR_ONE: begin
          if (tick_in) begin
            wr_state <= ecb_pkg::WR_TWO;
          end
        end
        ecb_pkg::WR_TWO: begin
          if (tick_in) begin
            wr_state <= (wr_mask_l == '0) ? ecb_pkg::WR_IDLE
              : ecb_pkg::WR_THREE;
          end
        end
        ecb_pkg::WR_THREE: begin
          if (tick_in) begin
            wr_state <= ecb_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_state <= ecb_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // entry storage, preset contents at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ecb_pkg::ENTRIES; i++) begin
        entry_data[i] <= ecb_pkg::INIT_BASE + 32'(i);
        entry_mask[i] <= ecb_pkg::INIT_MASK;
      end
    end else if (commit && !clr) begin
      entry_data[wr_addr_l] <= wr_data_l & ~wr_mask_l;
      entry_mask[wr_addr_l] <= wr_mask_l;
    end
  end

  // ==========================================================
  // search capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_cmp <= '0;
      cmp_pending <= 1'b0;
    end else begin
      if (load_low || clr) begin
        cmp_pending <= 1'b0;
      end
      if (go_s) begin
        key_cmp <= key_sel;
        cmp_pending <= 1'b1;
      end
    end
  end

  // output stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_state <= ecb_pkg::OUT_IDLE;
      match_q <= '0;
      match_lines <= '0;
      match_index <= '0;
      match_found <= 1'b0;
      match_multi <= 1'b0;
      result_half <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      case (out_state)
        ecb_pkg::OUT_IDLE: begin
          if (load_low) begin
            match_q <= match;
            match_index <= enc_idx;
            match_found <= hit_any;
            match_multi <= multi;
            result_half <= 1'b0;
            result_valid <= 1'b1;
            match_lines <= encoded ? '0 : match[ecb_pkg::LINES-1:0];
            if (!encoded) begin
              out_state <= ecb_pkg::OUT_LOW;
            end
          end
        end
        ecb_pkg::OUT_LOW: begin
          if (out_step) begin
            match_lines <= match_q[ecb_pkg::ENTRIES-1:ecb_pkg::LINES];
            result_half <= 1'b1;
            out_state <= ecb_pkg::OUT_IDLE;
          end
        end
        default: begin
          out_state <= ecb_pkg::OUT_IDLE;
        end
      endcase
      if (clr && !load_low) begin
        out_state <= ecb_pkg::OUT_IDLE;
        match_lines <= '0;
        match_index <= '0;
        match_found <= 1'b0;
        match_multi <= 1'b0;
        result_half <= 1'b0;
        result_valid <= 1'b0;
      end
    end
  end

endmodule

// ---- src/ecb_pkg.sv ----
// Purpose: shared constants and types of the embedded CAM block
// Assumes: 32-bit AHB-Lite register window, word-aligned registers
// Notes: offsets are byte addresses within the block window
package ecb_pkg;

  // ==========================================================
  // array geometry
  localparam int ENTRIES = 32;
  localparam int WORD_W = 32;
  localparam int LINES = 16;
  localparam int IDX_W = 5;
  localparam int DIV_W = 8;
  localparam int OFF_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [OFF_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [OFF_W-1:0] OFF_WDATA = 8'h04;
  localparam logic [OFF_W-1:0] OFF_WMASK = 8'h08;
  localparam logic [OFF_W-1:0] OFF_WADDR = 8'h0c;
  localparam logic [OFF_W-1:0] OFF_CMD = 8'h10;
  localparam logic [OFF_W-1:0] OFF_KEY = 8'h14;
  localparam logic [OFF_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [OFF_W-1:0] OFF_RESULT = 8'h1c;
  localparam logic [OFF_W-1:0] OFF_DIVIN = 8'h20;
  localparam logic [OFF_W-1:0] OFF_DIVOUT = 8'h24;
  localparam logic [OFF_W-1:0] OFF_RADDR = 8'h28;
  localparam logic [OFF_W-1:0] OFF_RDATA = 8'h2c;

  // ==========================================================
  // control fields (1 = registered stage for the stage bits)
  localparam int CTRL_ENC = 0;
  localparam int CTRL_REG_DIN = 1;
  localparam int CTRL_REG_DOUT = 2;
  localparam int CTRL_REG_RADDR = 3;
  localparam int CTRL_REG_WADDR = 4;
  localparam int CTRL_REG_WSTB = 5;
  localparam int CTRL_REG_RSTB = 6;
  localparam int CTRL_CLKEN = 7;
  localparam int CTRL_CLEAR = 8;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'hff;

  // command and status fields
  localparam int CMD_WRITE = 0;
  localparam int CMD_SEARCH = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_VALID = 1;
  localparam int ST_FOUND = 2;
  localparam int ST_MULTI = 3;
  localparam int ST_HALF = 4;
  localparam int ST_SEARCH = 5;
  localparam int ST_IDX_LO = 8;
  localparam int RES_HALF = 16;

  // ==========================================================
  // reset values and bus constants
  localparam logic [WORD_W-1:0] INIT_BASE = 32'h0000_0000;
  localparam logic [WORD_W-1:0] INIT_MASK = 32'h0000_0000;
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;
  localparam int HTRANS_ACTIVE = 1;
  localparam logic RESP_OKAY = 1'b0;

  // ==========================================================
  // state machines
  typedef enum logic [3:0] {
    WR_IDLE = 4'h1,
    WR_ONE = 4'h2,
    WR_TWO = 4'h4,
    WR_THREE = 4'h8
  } ecb_wr_state_type;

  typedef enum logic [1:0] {
    OUT_IDLE = 2'h1,
    OUT_LOW = 2'h2
  } ecb_out_state_type;

endpackage

// ---- testbench/ecb_cam_block_tb.sv ----
// Purpose: self-checking bench for the cam block over ahb-lite
// Assumes: hready tied back to hreadyout, single word transfers
// Notes: a cycle ceiling ends a hung run
module ecb_cam_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, match_found, match_multi;
  logic result_half, result_valid;
  logic [ecb_pkg::LINES-1:0] match_lines;
  logic [ecb_pkg::IDX_W-1:0] match_index;
  logic [31:0] full_vec;
  wire logic hready;
  int vec_count, n;
  logic [31:0] st;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  assign hready = hreadyout;

  initial begin
    forever #2 hclk = ~hclk;
  end

  ecb_cam_block i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .match_lines(match_lines),
    .match_index(match_index), .match_found(match_found),
    .match_multi(match_multi), .result_half(result_half),
    .result_valid(result_valid)
  );

  ecb_result_reader i_reader (
    .hclk(hclk), .hresetn(hresetn), .match_lines(match_lines),
    .result_half(result_half), .result_valid(result_valid),
    .full_vec(full_vec), .vec_count(vec_count)
  );

  // ==========================================================
  // reporting
  task summarize;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize;
    end
  end

  // ==========================================================
  // bus access
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    logic r;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin
      @(negedge hclk);
      r = hready;
      @(posedge hclk);
    end while (!r);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(negedge hclk);
      r = hready;
      rd = hrdata;
      @(posedge hclk);
    end while (!r);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask

  task srch(input logic [31:0] key);
    wr(ecb_pkg::OFF_KEY, key);
    wr(ecb_pkg::OFF_CMD, 32'h2);
    repeat (3) @(posedge hclk);
    #1;
  endtask

  task put(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    logic [31:0] s;
    wr(ecb_pkg::OFF_WDATA, d);
    wr(ecb_pkg::OFF_WMASK, m);
    wr(ecb_pkg::OFF_WADDR, {27'h0, a});
    wr(ecb_pkg::OFF_CMD, 32'h1);
    do bus(1'b0, ecb_pkg::OFF_STATUS, 32'h0, s); while (s[0]);
  endtask

  task res(input logic [4:0] i, input logic f, input logic m);
    chk("index", {27'h0, i}, {27'h0, match_index});
    chk("found", {31'h0, f}, {31'h0, match_found});
    chk("multi", {31'h0, m}, {31'h0, match_multi});
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(ecb_pkg::OFF_CTRL, 32'hff, "ctrl reset");
    rdc(8'h3c, 32'h0, "unmapped");
    wr(ecb_pkg::OFF_RADDR, 32'h5);
    rdc(ecb_pkg::OFF_RDATA, 32'h5, "initial entry");
    wr(ecb_pkg::OFF_KEY, 32'hc);
    wr(ecb_pkg::OFF_CMD, 32'h2);
    #1;
    chk("valid early", 32'h0, {31'h0, result_valid});
    @(posedge hclk);
    #1;
    chk("valid", 32'h1, {31'h0, result_valid});
    res(5'd12, 1'b1, 1'b0);
    chk("lines enc", 32'h0, {16'h0, match_lines});
    put(5'd3, 32'habcd0000, 32'h0000ffff);
    wr(ecb_pkg::OFF_RADDR, 32'h3);
    rdc(ecb_pkg::OFF_RDATA, 32'habcd0000, "masked data");
    srch(32'habcd1234);
    res(5'd3, 1'b1, 1'b0);
    srch(32'habce1234);
    res(5'd0, 1'b0, 1'b0);
    put(5'd20, 32'hc, 32'h0);
    srch(32'hc);
    res(5'd12, 1'b1, 1'b1);
    wr(ecb_pkg::OFF_CTRL, 32'hfe);
    n = vec_count;
    srch(32'hc);
    repeat (2) @(posedge hclk);
    #1;
    chk("vector", 32'h0010_1000, full_vec);
    chk("beats", n + 1, vec_count);
    wr(ecb_pkg::OFF_DIVOUT, 32'h3);
    rdc(ecb_pkg::OFF_DIVOUT, 32'h3, "divout");
    srch(32'h5);
    repeat (12) @(posedge hclk);
    #1;
    chk("slow vector", 32'h0000_0020, full_vec);
    wr(ecb_pkg::OFF_DIVIN, 32'h3);
    rdc(ecb_pkg::OFF_DIVIN, 32'h3, "divin");
    wr(ecb_pkg::OFF_WDATA, 32'h77);
    wr(ecb_pkg::OFF_WMASK, 32'h0);
    wr(ecb_pkg::OFF_WADDR, 32'h9);
    wr(ecb_pkg::OFF_CMD, 32'h1);
    // slow input side: the write cannot have committed yet
    bus(1'b0, ecb_pkg::OFF_STATUS, 32'h0, st);
    chk("slow busy", 32'h1, {31'h0, st[ecb_pkg::ST_BUSY]});
    do bus(1'b0, ecb_pkg::OFF_STATUS, 32'h0, st); while (st[0]);
    wr(ecb_pkg::OFF_DIVIN, 32'h0);
    wr(ecb_pkg::OFF_RADDR, 32'h9);
    rdc(ecb_pkg::OFF_RDATA, 32'h77, "slow write");
    wr(ecb_pkg::OFF_DIVOUT, 32'h0);
    wr(ecb_pkg::OFF_CTRL, 32'h1fe);
    @(posedge hclk);
    #1;
    chk("cleared", 32'h0, {31'h0, result_valid});
    wr(ecb_pkg::OFF_CTRL, 32'h07e);
    srch(32'h7);
    chk("frozen", 32'h0, {31'h0, result_valid});
    wr(ecb_pkg::OFF_CTRL, 32'hff);
    repeat (5) @(posedge hclk);
    // the registered key stage froze holding the earlier key
    res(5'd5, 1'b1, 1'b0);
    wr(ecb_pkg::OFF_CTRL, 32'h81);
    srch(32'h7);
    res(5'd7, 1'b1, 1'b0);
    summarize;
  end
endmodule

// ---- testbench/ecb_cam_chk.sv ----
// Purpose: port-level assertions for the cam block
// Assumes: one clock domain, hready looped back from hreadyout
// Notes: attached to the design by the bind at the foot of this file
module ecb_cam_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // result
  input wire logic [ecb_pkg::LINES-1:0] match_lines,
  input wire logic [ecb_pkg::IDX_W-1:0] match_index,
  input wire logic match_found,
  input wire logic match_multi,
  input wire logic result_half,
  input wire logic result_valid
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // bus
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  wait_state_a: assert property (hsel && hready && htrans[1] |=>
    !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  single_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("hreadyout low for two cycles");

  // ==========================================================
  // result
  multi_found_a: assert property (match_multi |-> match_found)
    else $error("multi without found");
  no_match_idx_a: assert property (
    !match_found && !result_half |-> match_index == 5'h00)
    else $error("index nonzero without a match");
  lines_valid_a: assert property (
    match_lines != 16'h0000 |-> result_valid)
    else $error("match lines before any result");
  found_valid_a: assert property (match_found |-> result_valid)
    else $error("found before any result");
  high_beat_a: assert property (
    $rose(result_half) |-> $past(result_valid))
    else $error("high beat without a loaded result");
endmodule

bind ecb_cam_block ecb_cam_chk i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .match_lines(match_lines), .match_index(match_index),
  .match_found(match_found), .match_multi(match_multi),
  .result_half(result_half), .result_valid(result_valid)
);

// ---- testbench/ecb_result_reader.sv ----
// Purpose: user logic that gathers the two unencoded beats
// Assumes: low beat shows while result_half is 0, high beat follows
// Notes: full_vec holds entries 31..0, vec_count counts gathered vectors
module ecb_result_reader (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // result lines
  input wire logic [ecb_pkg::LINES-1:0] match_lines,
  input wire logic result_half,
  input wire logic result_valid,
  // gathered vector
  output logic [31:0] full_vec,
  output int vec_count
);
  logic [15:0] low_q;
  logic half_q;

  // both beats are needed for the full picture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q <= 16'h0000;
      half_q <= 1'b0;
      full_vec <= 32'h0000_0000;
      vec_count <= 0;
    end else begin
      half_q <= result_half;
      if (!result_half) begin
        low_q <= match_lines;
      end
      if (result_valid && result_half && !half_q) begin
        full_vec <= {match_lines, low_q};
        vec_count <= vec_count + 1;
      end
    end
  end
endmodule
